//--- include/tcm_pkg.sv
// Purpose: Shared constants and carriers of the trace condition matcher
// Assumes: 32-bit Avalon-MM register slave, byte addresses
// Notes:   One aligned word per register
package tcm_pkg;
    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_DVAL   = 5'h04;
    localparam logic [4:0] OFS_DMASK  = 5'h08;
    localparam logic [4:0] OFS_PINS   = 5'h0C;
    localparam logic [4:0] OFS_COUNT  = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;
    localparam logic [4:0] OFS_IMASK  = 5'h18;
    localparam logic [4:0] OFS_REMAIN = 5'h1C;

    // ************************************************************
    // Field encodings and reset values
    // ************************************************************
    localparam logic [1:0]  TYPE_A     = 2'h0;
    localparam logic [1:0]  TYPE_B     = 2'h1;
    localparam logic [1:0]  TYPE_C     = 2'h2;
    localparam logic [1:0]  WID_BYTE   = 2'h0;
    localparam logic [1:0]  WID_WORD   = 2'h1;
    localparam logic [1:0]  WID_LONG   = 2'h2;
    localparam int          ST_MATCH   = 0;
    localparam int          ST_MET     = 1;
    localparam int          ST_W       = 2;
    localparam logic [31:0] CTRL_RST   = 32'h00000000;
    localparam logic [31:0] DMASK_RST  = 32'hFFFFFFFF;
    localparam logic [15:0] COUNT_RST  = 16'h0001;

    // Control word, bit 0 at the bottom
    typedef struct packed {
        logic [14:0] rsvd;
        logic        nmi_high;
        logic        nmi_en;
        logic        dir_write;
        logic        dir_en;
        logic        access_dma;
        logic        access_en;
        logic        data_not;
        logic        data_masked;
        logic [1:0]  lane;
        logic [1:0]  width;
        logic        data_en;
        logic        stop;
        logic [1:0]  ctype;
        logic        enable;
    } tcm_ctrl_s;

    // One target bus cycle with its side signals
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        dma;
        logic [31:0] data;
        logic [3:0]  probe;
        logic        nmi;
        logic [7:0]  irq;
    } tcm_bus_s;
endpackage

//--- logic/tcm_matcher.sv
// Purpose: Trace acquisition condition matcher for one channel
// Assumes: Target bus cycles arrive on core_clk_in, one valid per cycle
// Notes:   Address matching is done elsewhere
//
// What this block does
// - Select byte lane or word half compared
// - Compare 8, 16, 32 bits, exact or masked
// - Mask ignores excluded data bit positions
// - Inversion matches every value but the given
// - Restrict to data access or DMA cycles
// - Restrict to read only or write only
// - Direction check only for types a, b
// - Four probes compared per level, types a, b
// - Don't-care probe bits are excluded
// - Optional NMI high or low, types a, b
// - Eight request lines compared, types a, b
// - Don't-care request bits are excluded
// - Pass count 1 to 65535 before satisfied
// - Pass count only for stop, types a, b
// - Data compared only for types a, b
`timescale 1ns/1ns
module tcm_matcher #(
    parameter int COUNT_W = 16
) (
    input  wire logic              core_clk_in,
    input  wire logic              srst_in,
    input  wire logic [4:0]        avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    output logic [31:0]            avs_readdata_out,
    output logic                   avs_waitrequest_out,
    input  wire tcm_pkg::tcm_bus_s bus_in,
    output logic                   match_out,
    output logic                   cond_met_out,
    output logic                   halted_out,
    output logic                   irq_out
);
    // ************************************************************
    // Parameter check
    // ************************************************************
    if (COUNT_W < 1 || COUNT_W > 16)
    begin : g_bad_w
        $error("COUNT_W must be 1 to 16");
    end

    // ************************************************************
    // Registers and bus slave
    // ************************************************************
    tcm_pkg::tcm_ctrl_s         ctrl;
    logic [31:0]                dval;
    logic [31:0]                dmask;
    logic [31:0]                pins;
    logic [COUNT_W-1:0]         count;
    logic [tcm_pkg::ST_W-1:0]   status;
    logic [tcm_pkg::ST_W-1:0]   imask;
    logic [COUNT_W-1:0]         remain;
    logic [COUNT_W-1:0]         load_val;
    logic                       ack;
    logic                       wr_go;
    logic                       rearm;
    logic [tcm_pkg::ST_W-1:0]   ev;
    logic [31:0]                next_rdata;

    // Apply byte enables to a stored word
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // One wait state: the answer comes on the second edge of a request
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
    assign wr_go = avs_write_in & ack;
    // Writing the control or count register restarts the pass count
    assign rearm = wr_go && (avs_address_in == tcm_pkg::OFS_CTRL ||
                             avs_address_in == tcm_pkg::OFS_COUNT);
    // A count write reloads from the new value, not the stale one
    assign load_val = (avs_address_in == tcm_pkg::OFS_COUNT) ?
        COUNT_W'(be_merge(32'(count), avs_writedata_in, avs_byteenable_in))
        : count;

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            ack <= 1'b0;
        end
        else
        begin
            ack <= (avs_read_in | avs_write_in) & ~ack;
        end
    end

    // Read mux, unmapped offsets read as zero
    always_comb
    begin
        next_rdata = 32'h00000000;
        case (avs_address_in)
            tcm_pkg::OFS_CTRL:   next_rdata = ctrl;
            tcm_pkg::OFS_DVAL:   next_rdata = dval;
            tcm_pkg::OFS_DMASK:  next_rdata = dmask;
            tcm_pkg::OFS_PINS:   next_rdata = {8'h00, pins[23:0]};
            tcm_pkg::OFS_COUNT:  next_rdata = 32'(count);
            tcm_pkg::OFS_STATUS: next_rdata = 32'(status);
            tcm_pkg::OFS_IMASK:  next_rdata = 32'(imask);
            tcm_pkg::OFS_REMAIN: next_rdata = 32'(remain);
            default:             next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            avs_readdata_out <= 32'h00000000;
        end
        else if (avs_read_in && !ack)
        begin
            avs_readdata_out <= next_rdata;
        end
    end

    // Software-owned setup registers
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            ctrl  <= tcm_pkg::CTRL_RST;
            dval  <= 32'h00000000;
            dmask <= tcm_pkg::DMASK_RST;
            pins  <= 32'h00000000;
            count <= COUNT_W'(tcm_pkg::COUNT_RST);
            imask <= '0;
        end
        else if (wr_go)
        begin
            case (avs_address_in)
                tcm_pkg::OFS_CTRL:
                    ctrl <= be_merge(ctrl, avs_writedata_in,
                                     avs_byteenable_in) & 32'h0001FFFF;
                tcm_pkg::OFS_DVAL:
                    dval <= be_merge(dval, avs_writedata_in,
                                     avs_byteenable_in);
                tcm_pkg::OFS_DMASK:
                    dmask <= be_merge(dmask, avs_writedata_in,
                                      avs_byteenable_in);
                tcm_pkg::OFS_PINS:
                    pins <= be_merge(pins, avs_writedata_in,
                                     avs_byteenable_in) & 32'h00FFFFFF;
                tcm_pkg::OFS_COUNT:
                    count <= COUNT_W'(be_merge(32'(count), avs_writedata_in,
                                               avs_byteenable_in));
                tcm_pkg::OFS_IMASK:
                    imask <= avs_writedata_in[tcm_pkg::ST_W-1:0];
                default:
                    imask <= imask;
            endcase
        end
    end

    // ************************************************************
    // Condition evaluation
    // ************************************************************
    logic        type_ab;
    logic [31:0] lane_val;
    logic [31:0] lane_ref;
    logic [31:0] wmask;
    logic        data_eq;
    logic        data_ok;
    logic        access_ok;
    logic        dir_ok;
    logic        probe_ok;
    logic        nmi_ok;
    logic        irq_ok;
    logic        hit;
    logic        counting;

    assign type_ab = ctrl.ctype == tcm_pkg::TYPE_A ||
                     ctrl.ctype == tcm_pkg::TYPE_B;

    // Shift the chosen lane down; reference value sits in low bits
    always_comb
    begin
        lane_val = bus_in.data;
        wmask    = 32'hFFFFFFFF;
        case (ctrl.width)
            tcm_pkg::WID_BYTE:
            begin
                lane_val = bus_in.data >> {ctrl.lane, 3'h0};
                wmask    = 32'h000000FF;
            end
            tcm_pkg::WID_WORD:
            begin
                lane_val = bus_in.data >> {ctrl.lane[0], 4'h0};
                wmask    = 32'h0000FFFF;
            end
            default:
            begin
                lane_val = bus_in.data;
                wmask    = 32'hFFFFFFFF;
            end
        endcase
    end

    // Exact form compares every lane bit, masked form only mask ones
    assign lane_ref = ctrl.data_masked ? (wmask & dmask) : wmask;
    assign data_eq  = ((lane_val ^ dval) & lane_ref) == 32'h00000000;
    assign data_ok  = !ctrl.data_en || !type_ab ||
                      (data_eq ^ ctrl.data_not);
    assign access_ok = !ctrl.access_en ||
                       (bus_in.dma == ctrl.access_dma);
    assign dir_ok   = !ctrl.dir_en || !type_ab ||
                      (bus_in.write == ctrl.dir_write);
    assign probe_ok = !type_ab ||
                      ((bus_in.probe ^ pins[3:0]) & pins[7:4]) == 4'h0;
    assign nmi_ok   = !ctrl.nmi_en || !type_ab ||
                      (bus_in.nmi == ctrl.nmi_high);
    assign irq_ok   = !type_ab ||
                      ((bus_in.irq ^ pins[15:8]) & pins[23:16]) == 8'h00;
    assign hit = ctrl.enable && bus_in.valid && data_ok && access_ok &&
                 dir_ok && probe_ok && nmi_ok && irq_ok;
    // Pass counting is meaningful only for stop on types a and b
    assign counting = ctrl.stop && type_ab;

    // ************************************************************
    // Pass counter and outputs
    // ************************************************************
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            remain       <= COUNT_W'(tcm_pkg::COUNT_RST);
            halted_out   <= 1'b0;
            cond_met_out <= 1'b0;
            match_out    <= 1'b0;
        end
        else
        begin
            match_out    <= hit;
            cond_met_out <= 1'b0;
            if (rearm)
            begin
                // Zero would never expire, so it behaves as one
                remain     <= (load_val == '0) ? COUNT_W'(1) : load_val;
                halted_out <= 1'b0;
            end
            else if (!counting)
            begin
                cond_met_out <= hit;
            end
            else if (hit && !halted_out)
            begin
                if (remain <= COUNT_W'(1))
                begin
                    remain       <= '0;
                    halted_out   <= 1'b1;
                    cond_met_out <= 1'b1;
                end
                else
                begin
                    remain <= remain - COUNT_W'(1);
                end
            end
        end
    end

    // Sticky status, write one to clear, a new event wins
    assign ev[tcm_pkg::ST_MATCH] = hit;
    assign ev[tcm_pkg::ST_MET]   = counting ? (hit && !halted_out && !rearm
                                   && remain <= COUNT_W'(1))
                                   : (hit && !rearm);
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            status <= '0;
        end
        else
        begin
            status <= (status & ~((wr_go && avs_address_in ==
                        tcm_pkg::OFS_STATUS) ?
                        avs_writedata_in[tcm_pkg::ST_W-1:0] : '0)) | ev;
        end
    end
    assign irq_out = |(status & imask);

    // ************************************************************
    // Checks
    // ************************************************************
    match_and_a: assert property (@(posedge core_clk_in)
        disable iff (srst_in) !hit |=> !match_out)
        else $error("match without all parts true");
    invert_data_a: assert property (@(posedge core_clk_in)
        disable iff (srst_in) ctrl.data_en && ctrl.data_not && data_eq &&
        type_ab |=> !match_out) else $error("inverted data matched");
    type_c_free_a: assert property (@(posedge core_clk_in)
        disable iff (srst_in) ctrl.enable && bus_in.valid && !ctrl.access_en
        && ctrl.ctype == tcm_pkg::TYPE_C |=> match_out)
        else $error("type c cycle not matched");
    access_sel_a: assert property (@(posedge core_clk_in)
        disable iff (srst_in) ctrl.access_en && bus_in.dma != ctrl.access_dma
        |=> !match_out) else $error("wrong bus status matched");
    dir_sel_a: assert property (@(posedge core_clk_in)
        disable iff (srst_in) type_ab && ctrl.dir_en &&
        bus_in.write != ctrl.dir_write |=> !match_out)
        else $error("wrong direction matched");
    probe_care_a: assert property (@(posedge core_clk_in)
        disable iff (srst_in) type_ab &&
        ((bus_in.probe ^ pins[3:0]) & pins[7:4]) != 4'h0 |=> !match_out)
        else $error("probe mismatch matched");
    irq_care_a: assert property (@(posedge core_clk_in)
        disable iff (srst_in) type_ab &&
        ((bus_in.irq ^ pins[15:8]) & pins[23:16]) != 8'h00 |=> !match_out)
        else $error("request line mismatch matched");
    nmi_level_a: assert property (@(posedge core_clk_in)
        disable iff (srst_in) type_ab && ctrl.nmi_en &&
        bus_in.nmi != ctrl.nmi_high |=> !match_out)
        else $error("nmi level mismatch matched");
    pass_zero_a: assert property (@(posedge core_clk_in)
        disable iff (srst_in) counting && !rearm && hit && !halted_out &&
        remain > COUNT_W'(1) |=> !cond_met_out &&
        remain == $past(remain) - COUNT_W'(1))
        else $error("pass count expired early");
    range_pass_a: assert property (@(posedge core_clk_in)
        disable iff (srst_in) !counting && !rearm && hit |=> cond_met_out)
        else $error("uncounted match not passed");
    halt_hold_a: assert property (@(posedge core_clk_in)
        disable iff (srst_in) counting && halted_out && !rearm
        |=> !cond_met_out) else $error("met again after halt");
endmodule

//--- verification/tcm_target_model.sv
// Purpose: Target processor bus model that feeds the trace matcher
// Assumes: One bus cycle is launched for each go_in pulse
// Notes:   Data and probe lines drift between cycles, never hold
`timescale 1ns/1ns
module tcm_target_model (
    input  wire logic              core_clk_in,
    input  wire logic              srst_in,
    input  wire logic              go_in,
    input  wire tcm_pkg::tcm_bus_s cyc_in,
    output tcm_pkg::tcm_bus_s      bus_out
);
    // ************************************************************
    // Bus cycle launch
    // ************************************************************
    // Idle lanes toggle so a stale value can never pass for a match
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            bus_out <= '0;
        end
        else if (go_in)
        begin
            bus_out <= {1'b1, cyc_in[$bits(tcm_pkg::tcm_bus_s)-2:0]};
        end
        else
        begin
            bus_out.valid <= 1'b0;
            bus_out.data  <= ~bus_out.data;
            bus_out.probe <= ~bus_out.probe;
        end
    end
endmodule

//--- verification/tb_tcm_matcher.sv
// Purpose: Self-checking bench of the trace condition matcher
// Assumes: One register wait state, match one cycle after a bus cycle
// Notes:   Bus answers taken at the rising edge, pulses at the falling one
`timescale 1ns/1ns
module tb_tcm_matcher;
    logic              core_clk, srst, rd_en, wr_en, go;
    logic [4:0]        addr;
    logic [31:0]       wdata, rdata, d;
    logic              waitreq, match, met, halted, irq;
    tcm_pkg::tcm_bus_s cyc, bus;
    int                n_errors, tests_run, l;

    tcm_matcher DUT (.core_clk_in(core_clk), .srst_in(srst),
        .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
        .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .bus_in(bus), .match_out(match), .cond_met_out(met),
        .halted_out(halted), .irq_out(irq));
    tcm_target_model target (.core_clk_in(core_clk), .srst_in(srst),
        .go_in(go), .cyc_in(cyc), .bus_out(bus));

    // 250 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ************************************************************
    // Compare and report
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ************************************************************
    // Avalon-MM master
    // ************************************************************
    // Waitrequest and read data are taken at one rising edge
    task automatic acc(input logic w, input logic [4:0] a,
                       input logic [31:0] v);
        int i;
        @(posedge core_clk);
        addr  <= a;
        wr_en <= w;
        rd_en <= ~w;
        wdata <= v;
        i = 0;
        do
        begin
            @(posedge core_clk);
            i++;
        end
        while (waitreq !== 1'b0 && i < 20);
        d = rdata;
        if (waitreq !== 1'b0)
        begin
            n_errors++;
            close_out();
        end
        else
        begin
            wr_en <= 1'b0;
            rd_en <= 1'b0;
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        acc(1'b1, a, v);
    endtask

    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h00000000);
        chk(d, e);
    endtask

    // ************************************************************
    // Target bus cycles
    // ************************************************************
    function automatic tcm_pkg::tcm_bus_s cy(logic w, logic dm,
        logic [31:0] dt, logic [3:0] p, logic n, logic [7:0] q);
        cy = {1'b1, w, dm, dt, p, n, q};
    endfunction

    // Launch one cycle, then check the pulses that follow it
    task automatic tm(input tcm_pkg::tcm_bus_s c, input logic em,
                      input logic ec);
        @(posedge core_clk);
        go  <= 1'b1;
        cyc <= c;
        @(posedge core_clk);
        go <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, match}, {31'h0, em});
        chk({31'h0, met}, {31'h0, ec});
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        {srst, rd_en, wr_en, go, addr, wdata, cyc} = '0;
        srst = 1'b1;
        n_errors = 0;
        tests_run = 0;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        // Reset values, unmapped place, write ignored there
        rdc(tcm_pkg::OFS_CTRL, tcm_pkg::CTRL_RST);
        rdc(tcm_pkg::OFS_DMASK, tcm_pkg::DMASK_RST);
        rdc(tcm_pkg::OFS_COUNT, {16'h0, tcm_pkg::COUNT_RST});
        rdc(tcm_pkg::OFS_REMAIN, 32'h00000001);
        wr(5'h02, 32'hFFFFFFFF);
        rdc(5'h02, 32'h00000000);
        tm(cy(0, 0, 32'h0, 4'h0, 0, 8'h0), 1'b0, 1'b0);
        $display("test reset done");
        // Byte lanes, word halves and long, exact
        wr(tcm_pkg::OFS_DVAL, 32'h000000A5);
        for (l = 0; l < 4; l++)
        begin
            wr(tcm_pkg::OFS_CTRL, 32'h00000011 | (32'(l) << 7));
            tm(cy(0, 0, 32'hA5 << (8 * l), 0, 0, 0), 1, 1);
            tm(cy(0, 0, 32'hA5 << (8 * ((l + 1) % 4)), 0, 0, 0), 0, 0);
        end
        wr(tcm_pkg::OFS_DVAL, 32'h00001234);
        for (l = 0; l < 2; l++)
        begin
            wr(tcm_pkg::OFS_CTRL, 32'h00000031 | (32'(l) << 7));
            tm(cy(0, 0, 32'h1234 << (16 * l), 0, 0, 0), 1, 1);
            tm(cy(0, 0, 32'h1234 << (16 * (1 - l)), 0, 0, 0), 0, 0);
        end
        wr(tcm_pkg::OFS_DVAL, 32'h11111111);
        wr(tcm_pkg::OFS_CTRL, 32'h00000051);
        tm(cy(0, 0, 32'h11111111, 0, 0, 0), 1, 1);
        tm(cy(0, 0, 32'h11111110, 0, 0, 0), 0, 0);
        // Data and NMI high together, and type c without data
        wr(tcm_pkg::OFS_CTRL, 32'h00018051);
        tm(cy(0, 0, 32'h11111111, 0, 1, 0), 1, 1);
        tm(cy(0, 0, 32'h11111111, 0, 0, 0), 0, 0);
        wr(tcm_pkg::OFS_CTRL, 32'h00000055);
        tm(cy(0, 0, 32'h0, 0, 0, 0), 1, 1);
        // Masked and inverted data
        wr(tcm_pkg::OFS_DMASK, 32'h0000FFFF);
        wr(tcm_pkg::OFS_DVAL, 32'h00004750);
        wr(tcm_pkg::OFS_CTRL, 32'h00000251);
        tm(cy(0, 0, 32'hABCD4750, 0, 0, 0), 1, 1);
        tm(cy(0, 0, 32'hABCD4751, 0, 0, 0), 0, 0);
        wr(tcm_pkg::OFS_DVAL, 32'h0000005A);
        wr(tcm_pkg::OFS_CTRL, 32'h00000411);
        tm(cy(0, 0, 32'h5A, 0, 0, 0), 0, 0);
        tm(cy(0, 0, 32'h5B, 0, 0, 0), 1, 1);
        $display("test data done");
        // Bus status, direction, interrupt line
        wr(tcm_pkg::OFS_CTRL, 32'h00001801);
        tm(cy(0, 1, 0, 0, 0, 0), 1, 1);
        tm(cy(0, 0, 0, 0, 0, 0), 0, 0);
        wr(tcm_pkg::OFS_CTRL, 32'h00000801);
        tm(cy(0, 0, 0, 0, 0, 0), 1, 1);
        tm(cy(0, 1, 0, 0, 0, 0), 0, 0);
        wr(tcm_pkg::OFS_CTRL, 32'h00006001);
        tm(cy(1, 0, 0, 0, 0, 0), 1, 1);
        tm(cy(0, 0, 0, 0, 0, 0), 0, 0);
        wr(tcm_pkg::OFS_CTRL, 32'h00002001);
        tm(cy(0, 0, 0, 0, 0, 0), 1, 1);
        tm(cy(1, 0, 0, 0, 0, 0), 0, 0);
        wr(tcm_pkg::OFS_CTRL, 32'h00006005);
        tm(cy(0, 0, 0, 0, 0, 0), 1, 1);
        wr(tcm_pkg::OFS_CTRL, 32'h00018001);
        tm(cy(0, 0, 0, 0, 1, 0), 1, 1);
        tm(cy(0, 0, 0, 0, 0, 0), 0, 0);
        wr(tcm_pkg::OFS_CTRL, 32'h00008001);
        tm(cy(0, 0, 0, 0, 0, 0), 1, 1);
        tm(cy(0, 0, 0, 0, 1, 0), 0, 0);
        // Probe and request levels with don't-care positions
        wr(tcm_pkg::OFS_PINS, 32'h00F0A5E5);
        wr(tcm_pkg::OFS_CTRL, 32'h00000001);
        tm(cy(0, 0, 0, 4'h4, 0, 8'hAF), 1, 1);
        tm(cy(0, 0, 0, 4'h6, 0, 8'hA0), 0, 0);
        tm(cy(0, 0, 0, 4'h5, 0, 8'hB0), 0, 0);
        wr(tcm_pkg::OFS_CTRL, 32'h00000005);
        tm(cy(0, 0, 0, 4'hF, 0, 8'h00), 1, 1);
        wr(tcm_pkg::OFS_PINS, 32'h00000000);
        $display("test side signals done");
        // Pass count, halt, status event and interrupt
        wr(tcm_pkg::OFS_STATUS, 32'h00000003);
        wr(tcm_pkg::OFS_COUNT, 32'h00000003);
        wr(tcm_pkg::OFS_CTRL, 32'h0000000B);
        rdc(tcm_pkg::OFS_REMAIN, 32'h00000003);
        tm(cy(0, 0, 0, 0, 0, 0), 1, 0);
        tm(cy(0, 0, 0, 0, 0, 0), 1, 0);
        tm(cy(0, 0, 0, 0, 0, 0), 1, 1);
        chk({31'h0, halted}, 32'h00000001);
        rdc(tcm_pkg::OFS_REMAIN, 32'h00000000);
        tm(cy(0, 0, 0, 0, 0, 0), 1, 0);
        rdc(tcm_pkg::OFS_STATUS, 32'h00000003);
        chk({31'h0, irq}, 32'h00000000);
        wr(tcm_pkg::OFS_IMASK, 32'h00000002);
        @(negedge core_clk);
        chk({31'h0, irq}, 32'h00000001);
        wr(tcm_pkg::OFS_STATUS, 32'h00000002);
        rdc(tcm_pkg::OFS_STATUS, 32'h00000001);
        @(negedge core_clk);
        chk({31'h0, irq}, 32'h00000000);
        wr(tcm_pkg::OFS_COUNT, 32'hFFFFFFFF);
        rdc(tcm_pkg::OFS_COUNT, 32'h0000FFFF);
        rdc(tcm_pkg::OFS_REMAIN, 32'h0000FFFF);
        wr(tcm_pkg::OFS_COUNT, 32'h00000003);
        wr(tcm_pkg::OFS_CTRL, 32'h0000000D);
        tm(cy(0, 0, 0, 0, 0, 0), 1, 1);
        wr(tcm_pkg::OFS_CTRL, 32'h00000003);
        tm(cy(0, 0, 0, 0, 0, 0), 1, 1);
        $display("test pass count done");
        close_out();
    end
endmodule
